/* File: rtl/ifd_decode.sv */
`timescale 1ns/1ps
`include "ifd_map.svh"
// Summary of operation
// (RULE1) Instructions parsed one 16-bit word at a time
// (RULE2) Top four bits belong to operation field
// (RULE3) Address selectors 3 bits, data 3/4
// (RULE4) Two op fields, two or no registers
// (RULE5) Extension of 8, 16 or 32 bits
// (RULE6) 24-bit values fetched as 32, top ignored
// (RULE7) Branch condition from its own field
// (RULE8) Bit ops read, modify, write same byte
// (RULE9) Write-only direction register reads all ones
// (RULE10) Bit-clear read counts as flag read
// (RULE11) Eight addressing modes supported
// (RULE12) Arithmetic: register direct or immediate only
// (RULE13) Transfers: all but PC-relative, memory indirect
// (RULE14) Bit ops: direct, indirect, short absolute
// (RULE15) Register direct selects half, word, longword
// (RULE16) Indirect address is register low 24
// (RULE17) Displacement added, low 24 bits used
// (RULE18) Post-increment after, pre-decrement before, by size
// (RULE19) Short absolute ones-extended, 16-bit sign-extended
// (RULE20) PC displacement sign-extended, added to next
// (RULE21) Word, long, branch addresses forced even
// (RULE22) Mode, selectors, remaining extension words shown
// (RULE23) Illegal mode flagged, no memory access
module ifd_decode #(
   parameter int ADDR_W = 24,
   parameter logic [23:0] PORT_DIR_ADDR = `IFD_PORT_DIR_ADDR
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_word,
   output logic fetch_ready,
   input wire logic [ADDR_W-1:0] next_pc,
   output logic [2:0] rf_asel,
   input wire logic [31:0] rf_adata,
   output logic [3:0] rf_dsel,
   input wire logic [7:0] rf_ddata,
   output logic rf_we,
   output logic [2:0] rf_wsel,
   output logic [31:0] rf_wdata,
   output logic mem_req,
   output logic mem_we,
   output logic mem_long,
   output logic mem_flag_read,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic carry_in,
   output logic [3:0] operation_field,
   output ifd_pkg::ifd_mode_e mode,
   output ifd_pkg::ifd_size_t op_size,
   output logic [2:0] address_register,
   output logic [3:0] data_register,
   output logic [3:0] branch_condition_field,
   output logic [1:0] ext_remaining,
   output logic [31:0] imm_data,
   output logic [ADDR_W-1:0] ea_addr,
   output logic ea_valid,
   output logic undefined_op,
   output logic busy
);
   import ifd_pkg::*;

   // ==========================================
   // Parameter check
   // The address arithmetic is written for a 24-bit space only
   if (ADDR_W != 24) begin : g_bad_width
      $error("ifd_decode: ADDR_W must be 24");
   end

   // ==========================================
   // State
   ifd_state_e state_r, state_nxt;
   logic [15:0] w0_r;
   logic [31:0] ext_r;
   logic [1:0] cnt_r;
   logic [23:0] ea_r;
   logic [2:0] bitno_r;
   logic [7:0] mod_r;
   logic ea_valid_r, undef_r, rf_we_r;
   logic [31:0] rf_wdata_r;

   // ==========================================
   // Decode of the incoming first word
   wire [3:0] in_opf = fetch_word[`IFD_OPF_HI:`IFD_OPF_LO]; // RULE2
   wire [2:0] in_mode = fetch_word[`IFD_MODE_HI:`IFD_MODE_LO];
   wire [1:0] in_size = fetch_word[`IFD_SIZE_HI:`IFD_SIZE_LO];
   wire in_bit = (in_opf >= `IFD_C_BIT_SET) && (in_opf <= `IFD_C_BIT_TEST);
   wire in_cst = (in_opf == `IFD_C_CARRY_STORE) || (in_opf == `IFD_C_INV_CARRY_STORE);
   wire in_br = in_opf == `IFD_C_BRANCH;
   wire in_jmp = in_opf == `IFD_C_JUMP;
   wire i_rd = in_mode == IFD_M_REG;
   wire i_rind = in_mode == IFD_M_RIND;
   wire i_abs = in_mode == IFD_M_ABS;
   wire i_imm = in_mode == IFD_M_IMM;
   wire i_pcr = in_mode == IFD_M_PCREL;
   // Memory indirect shares the PC-relative code, told apart by class
   wire i_mind = i_pcr && in_jmp;
   // Branch length comes from size, bit and jump lengths are fixed
   wire [1:0] in_lsel = in_br ? in_size : in_bit ? `IFD_EXT_8 : in_jmp ?
                        (i_mind ? `IFD_EXT_8 : `IFD_EXT_32) : fetch_word[`IFD_LSEL_HI:`IFD_LSEL_LO];
   wire in_needs_ext = !(i_rd || i_rind || in_mode == IFD_M_PINC || in_mode == IFD_M_PDEC);
   wire [1:0] in_words = !in_needs_ext ? 2'h0 :
                         (in_lsel == `IFD_EXT_32) ? `IFD_WORDS_LONG : `IFD_WORDS_SHORT; // RULE5 RULE6
   // Mode permitted per class
   wire ok_arith = i_rd || i_imm; // RULE12
   wire ok_move = !i_pcr; // RULE13
   wire ok_bit = (i_rd || i_rind || (i_abs && in_lsel == `IFD_EXT_8)) &&
                 (in_size == `IFD_SZ_BYTE || (in_size == `IFD_BITSRC_REG && !in_cst)); // RULE14
   wire ok_br = i_pcr && in_lsel != `IFD_EXT_32; // RULE20
   wire ok_jmp = i_rind || i_abs || i_mind;
   wire ok_cls = (in_opf == `IFD_C_ARITH) ? ok_arith : (in_opf == `IFD_C_MOVE) ? ok_move :
                 in_bit ? ok_bit : in_br ? ok_br : in_jmp ? ok_jmp : 1'b0;
   wire ok_len = in_lsel != 2'h3 && !(in_mode == IFD_M_DISP && in_lsel == `IFD_EXT_8);
   wire in_legal = ok_cls && ok_len && (in_size != 2'h3); // RULE23

   // ==========================================
   // Latched word fields
   wire [3:0] opf = w0_r[`IFD_OPF_HI:`IFD_OPF_LO];
   wire [2:0] md = w0_r[`IFD_MODE_HI:`IFD_MODE_LO];
   wire is_bit = (opf >= `IFD_C_BIT_SET) && (opf <= `IFD_C_BIT_TEST);
   wire is_flow = (opf == `IFD_C_BRANCH) || (opf == `IFD_C_JUMP);
   wire is_mind = md == IFD_M_PCREL && opf == `IFD_C_JUMP;
   // Bit ops are byte wide, their size field picks the bit source
   wire [1:0] sz = is_bit ? `IFD_SZ_BYTE : w0_r[`IFD_SIZE_HI:`IFD_SIZE_LO];
   wire [1:0] lsel = (opf == `IFD_C_BRANCH) ? sz : is_bit ? `IFD_EXT_8 :
                     (opf == `IFD_C_JUMP) ? (is_mind ? `IFD_EXT_8 : `IFD_EXT_32) :
                     w0_r[`IFD_LSEL_HI:`IFD_LSEL_LO];
   wire bit_from_reg = w0_r[`IFD_SIZE_HI:`IFD_SIZE_LO] == `IFD_BITSRC_REG;

   // ==========================================
   // Effective address arithmetic
   wire [23:0] sx8 = {{16{ext_r[7]}}, ext_r[7:0]};
   wire [23:0] sx16 = {{8{ext_r[15]}}, ext_r[15:0]};
   wire [31:0] step = (sz == `IFD_SZ_LONG) ? `IFD_STEP_LONG :
                      (sz == `IFD_SZ_WORD) ? `IFD_STEP_WORD : `IFD_STEP_BYTE;
   wire [31:0] areg_inc = rf_adata + step; // RULE18
   wire [31:0] areg_dec = rf_adata - step; // RULE18
   wire [23:0] disp = (lsel == `IFD_EXT_16) ? sx16 : ext_r[23:0];
   wire [23:0] pc_disp = (lsel == `IFD_EXT_8) ? sx8 : sx16;
   logic [23:0] raw_ea;

   // Address by mode; top byte of a long extension is dropped
   always_comb begin
      unique case (md)
         IFD_M_REG, IFD_M_IMM: raw_ea = 24'h000000;
         IFD_M_RIND, IFD_M_PINC: raw_ea = rf_adata[23:0]; // RULE16
         IFD_M_DISP: raw_ea = rf_adata[23:0] + disp; // RULE17 RULE6
         IFD_M_PDEC: raw_ea = areg_dec[23:0];
         IFD_M_ABS: raw_ea = (lsel == `IFD_EXT_8) ? {`IFD_ABS8_TOP, ext_r[7:0]} :
                             (lsel == `IFD_EXT_16) ? sx16 : ext_r[23:0]; // RULE19
         IFD_M_PCREL: raw_ea = is_mind ? {`IFD_MIND_TOP, ext_r[7:0]} :
                               next_pc[23:0] + pc_disp; // RULE20
      endcase
   end

   // Word, long and flow targets may not be odd
   wire even_need = (sz != `IFD_SZ_BYTE) || is_flow;
   wire [23:0] calc_ea = {raw_ea[23:1], raw_ea[0] & ~even_need}; // RULE21
   wire [23:0] ind_tgt = {mem_rdata[23:1], 1'b0}; // RULE21
   wire bit_mem = is_bit && md != IFD_M_REG;
   wire do_wb = md == IFD_M_PINC || md == IFD_M_PDEC;

   // ==========================================
   // Bit modify
   // A write-only register reads as ones, so the write sets its other bits
   wire [7:0] rd_byte = (ea_r == PORT_DIR_ADDR) ? `IFD_WRONLY_READ : mem_rdata[7:0]; // RULE9
   wire [7:0] mod_byte;
   for (genvar i = 0; i < 8; i++) begin : g_mod
      logic nb;
      always_comb begin
         unique case (opf)
            `IFD_C_BIT_SET: nb = 1'b1;
            `IFD_C_BIT_CLEAR: nb = 1'b0;
            `IFD_C_BIT_INVERT: nb = ~rd_byte[i];
            `IFD_C_CARRY_STORE: nb = carry_in;
            `IFD_C_INV_CARRY_STORE: nb = ~carry_in;
            default: nb = rd_byte[i];
         endcase
      end
      assign mod_byte[i] = (bitno_r == 3'(i)) ? nb : rd_byte[i]; // RULE8
   end

   // ==========================================
   // Sequencer
   wire take = fetch_valid && fetch_ready;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         IFD_S_OP: if (take && in_legal) begin // RULE23
            state_nxt = (in_words != 2'h0) ? IFD_S_EXT : IFD_S_CALC;
         end
         IFD_S_EXT: if (take && cnt_r == 2'h1) begin
            state_nxt = IFD_S_CALC;
         end
         IFD_S_CALC: state_nxt = is_mind ? IFD_S_IND : bit_mem ? IFD_S_RD : IFD_S_OP;
         IFD_S_IND: if (mem_ack) begin
            state_nxt = IFD_S_OP;
         end
         IFD_S_RD: if (mem_ack) begin
            state_nxt = (opf == `IFD_C_BIT_TEST) ? IFD_S_OP : IFD_S_WR; // RULE8
         end
         IFD_S_WR: if (mem_ack) begin
            state_nxt = IFD_S_OP;
         end
         default: state_nxt = IFD_S_OP;
      endcase
   end

   // State and instruction word
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= IFD_S_OP;
         w0_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         if (take && state_r == IFD_S_OP) w0_r <= fetch_word; // RULE1
      end
   end

   // Extension words, one 16-bit word per transfer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ext_r <= 32'h00000000;
         cnt_r <= 2'h0;
      end else if (take && state_r == IFD_S_OP) begin
         ext_r <= 32'h00000000;
         cnt_r <= in_legal ? in_words : 2'h0; // RULE22
      end else if (take) begin
         ext_r <= {ext_r[15:0], fetch_word}; // RULE1 RULE5
         cnt_r <= cnt_r - 2'h1;
      end
   end

   // Address, bit number and modified byte
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ea_r <= 24'h000000;
         bitno_r <= 3'h0;
         mod_r <= 8'h00;
      end else begin
         if (state_r == IFD_S_CALC) ea_r <= calc_ea;
         if (state_r == IFD_S_CALC) bitno_r <= bit_from_reg ? rf_ddata[2:0] : w0_r[2:0]; // RULE14
         if (state_r == IFD_S_IND && mem_ack) ea_r <= ind_tgt;
         if (state_r == IFD_S_RD && mem_ack) mod_r <= mod_byte;
      end
   end

   // Register write-back lands one cycle after the address is formed
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rf_we_r <= 1'b0;
         rf_wdata_r <= 32'h00000000;
      end else begin
         rf_we_r <= state_r == IFD_S_CALC && do_wb;
         rf_wdata_r <= (md == IFD_M_PINC) ? areg_inc : areg_dec; // RULE18
      end
   end

   // Completion and undefined pulses
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ea_valid_r <= 1'b0;
         undef_r <= 1'b0;
      end else begin
         ea_valid_r <= (state_r == IFD_S_CALC && !is_mind && !bit_mem) ||
                       (state_r != IFD_S_CALC && state_r != IFD_S_EXT && state_r != IFD_S_OP && state_nxt == IFD_S_OP);
         undef_r <= take && state_r == IFD_S_OP && !in_legal; // RULE23
      end
   end

   // ==========================================
   // Outputs
   assign fetch_ready = state_r == IFD_S_OP || state_r == IFD_S_EXT;
   assign busy = state_r != IFD_S_OP;
   assign rf_asel = w0_r[`IFD_AREG_HI:`IFD_AREG_LO]; // RULE3
   assign rf_dsel = w0_r[`IFD_DREG_HI:`IFD_DREG_LO]; // RULE3
   assign rf_we = rf_we_r;
   assign rf_wsel = w0_r[`IFD_AREG_HI:`IFD_AREG_LO];
   assign rf_wdata = rf_wdata_r;
   assign mem_req = state_r == IFD_S_IND || state_r == IFD_S_RD || state_r == IFD_S_WR;
   assign mem_we = state_r == IFD_S_WR; // RULE8
   assign mem_long = state_r == IFD_S_IND;
   assign mem_flag_read = state_r == IFD_S_RD && opf == `IFD_C_BIT_CLEAR; // RULE10
   assign mem_addr = ea_r;
   assign mem_wdata = mod_r;
   assign operation_field = opf; // RULE2 RULE4
   assign mode = ifd_mode_e'(md); // RULE11 RULE22
   assign op_size = sz; // RULE15
   assign address_register = w0_r[`IFD_AREG_HI:`IFD_AREG_LO]; // RULE22
   assign data_register = w0_r[`IFD_DREG_HI:`IFD_DREG_LO]; // RULE15
   assign branch_condition_field = w0_r[`IFD_DREG_HI:`IFD_DREG_LO]; // RULE7
   assign ext_remaining = cnt_r; // RULE22
   assign imm_data = ext_r;
   assign ea_addr = ea_r;
   assign ea_valid = ea_valid_r;
   assign undefined_op = undef_r;
endmodule : ifd_decode

/* File: rtl/ifd_map.svh */
`ifndef IFD_MAP_SVH
`define IFD_MAP_SVH
// ==========================================
// First instruction word field positions
`define IFD_OPF_HI 15
`define IFD_OPF_LO 12
`define IFD_MODE_HI 11
`define IFD_MODE_LO 9
`define IFD_SIZE_HI 8
`define IFD_SIZE_LO 7
`define IFD_AREG_HI 6
`define IFD_AREG_LO 4
`define IFD_DREG_HI 3
`define IFD_DREG_LO 0
`define IFD_LSEL_HI 3
`define IFD_LSEL_LO 2
// ==========================================
// Instruction classes in the operation field
`define IFD_C_ARITH 4'h0
`define IFD_C_MOVE 4'h1
`define IFD_C_BRANCH 4'h2
`define IFD_C_JUMP 4'h3
`define IFD_C_BIT_SET 4'h4
`define IFD_C_BIT_CLEAR 4'h5
`define IFD_C_BIT_INVERT 4'h6
`define IFD_C_CARRY_STORE 4'h7
`define IFD_C_INV_CARRY_STORE 4'h8
`define IFD_C_BIT_TEST 4'h9
// ==========================================
// Operand sizes and extension lengths
`define IFD_SZ_BYTE 2'h0
`define IFD_SZ_WORD 2'h1
`define IFD_SZ_LONG 2'h2
`define IFD_BITSRC_REG 2'h1
`define IFD_EXT_8 2'h0
`define IFD_EXT_16 2'h1
`define IFD_EXT_32 2'h2
`define IFD_WORDS_SHORT 2'h1
`define IFD_WORDS_LONG 2'h2
`define IFD_STEP_BYTE 32'h00000001
`define IFD_STEP_WORD 32'h00000002
`define IFD_STEP_LONG 32'h00000004
// ==========================================
// Address constants
`define IFD_ABS8_TOP 16'hffff
`define IFD_MIND_TOP 16'h0000
`define IFD_WRONLY_READ 8'hff
`define IFD_PORT_DIR_ADDR 24'hfffe00
`endif

/* File: rtl/ifd_pkg.sv */
package ifd_pkg;
   typedef enum logic [2:0] {
      IFD_M_REG = 3'h0,
      IFD_M_RIND = 3'h1,
      IFD_M_DISP = 3'h2,
      IFD_M_PINC = 3'h3,
      IFD_M_PDEC = 3'h4,
      IFD_M_ABS = 3'h5,
      IFD_M_IMM = 3'h6,
      IFD_M_PCREL = 3'h7
   } ifd_mode_e;
   typedef enum logic [2:0] {
      IFD_S_OP = 3'h0,
      IFD_S_EXT = 3'h1,
      IFD_S_CALC = 3'h2,
      IFD_S_IND = 3'h3,
      IFD_S_RD = 3'h4,
      IFD_S_WR = 3'h5
   } ifd_state_e;
   typedef logic [1:0] ifd_size_t;
endpackage : ifd_pkg

/* File: verification/ifd_chk.sv */
`timescale 1ns/1ps
// ==========================================
// Port watcher for the decoder
module ifd_chk #(
   parameter int ADDR_W = 24
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_long,
   input wire logic mem_flag_read,
   input wire logic mem_ack,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic rf_we,
   input wire logic [31:0] rf_wdata,
   input wire logic [31:0] rf_adata,
   input wire logic [3:0] operation_field,
   input wire ifd_pkg::ifd_mode_e mode,
   input wire ifd_pkg::ifd_size_t op_size,
   input wire logic ea_valid,
   input wire logic [ADDR_W-1:0] ea_addr,
   input wire logic undefined_op,
   input wire logic busy
);
   import ifd_pkg::*;
   logic [31:0] step;
   // Register step follows operand size
   assign step = (op_size == 2'h2) ? 32'h4 : ((op_size == 2'h1) ? 32'h2 : 32'h1);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ==========================================
   // Assertions
   chk_undef_quiet: assert property (undefined_op |-> !mem_req && !busy)
      else $error("memory access on undefined encoding");
   chk_arith_modes: assert property (ea_valid && operation_field == 4'h0 |-> mode inside {IFD_M_REG, IFD_M_IMM})
      else $error("arithmetic took a forbidden mode");
   chk_flag_read: assert property (mem_flag_read |-> mem_req && !mem_we && operation_field == 4'h5)
      else $error("flag read outside bit clear read");
   chk_rmw_order: assert property (mem_req && mem_we && !$past(mem_we) |-> $past(mem_ack && !mem_we)
      && mem_addr == $past(mem_addr))
      else $error("write not after read of same byte");
   chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped before ack");
   chk_long_jump: assert property (mem_req && mem_long |-> operation_field == 4'h3 && !mem_we
      && mem_addr[23:8] == 16'h0000)
      else $error("long read outside memory indirect");
   chk_ea_even: assert property (ea_valid && operation_field < 4'h4 && mode != IFD_M_REG && mode != IFD_M_IMM
      && (op_size != 2'h0 || operation_field == 4'h2) |-> !ea_addr[0])
      else $error("odd word or branch address");
   chk_step_size: assert property (rf_we |-> rf_wdata == ((mode == IFD_M_PDEC) ? rf_adata - step : rf_adata + step))
      else $error("address register step wrong");
endmodule : ifd_chk

bind ifd_decode ifd_chk #(.ADDR_W(ADDR_W)) chk_u (.mclk, .nrst, .mem_req, .mem_we, .mem_long, .mem_flag_read,
   .mem_ack, .mem_addr, .rf_we, .rf_wdata, .rf_adata, .operation_field, .mode, .op_size, .ea_valid, .ea_addr,
   .undefined_op, .busy);

/* File: verification/ifd_far_mdl.sv */
`timescale 1ns/1ps
// ==========================================
// Register file and memory beyond the decoder
module ifd_far_mdl (
   input wire logic mclk,
   input wire logic [2:0] rf_asel,
   input wire logic [3:0] rf_dsel,
   input wire logic rf_we,
   input wire logic [2:0] rf_wsel,
   input wire logic [31:0] rf_wdata,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_long,
   input wire logic mem_flag_read,
   input wire logic [23:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [31:0] rf_adata,
   output logic [7:0] rf_ddata,
   output logic [31:0] mem_rdata,
   output logic mem_ack = 1'b0
);
   logic [31:0] regs [8] = '{default: 32'h0};
   logic [31:0] rd_val = 32'h0;
   logic [23:0] rd_addr, wr_addr;
   logic [7:0] wr_data;
   logic rd_flag, rd_long;
   int lat = 1;
   int cnt = 0;
   int n_wr = 0;
   int n_acc = 0;
   // Register reads are combinational
   assign rf_adata = regs[rf_asel];
   assign rf_ddata = regs[rf_dsel[2:0]][7:0];
   // Bus shows inverted data off ack, so stale reads never pass
   assign mem_rdata = mem_ack ? rd_val : ~rd_val;
   // Ack after lat+1 cycles of waiting request, one cycle per access
   always @(posedge mclk) begin
      if (rf_we) regs[rf_wsel] <= rf_wdata;
      if (mem_req && mem_ack) begin
         n_acc <= n_acc + 1;
         if (mem_we) begin
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
            n_wr <= n_wr + 1;
         end else begin
            rd_addr <= mem_addr;
            rd_flag <= mem_flag_read;
            rd_long <= mem_long;
         end
      end
      if (mem_ack || !mem_req) begin
         mem_ack <= 1'b0;
         cnt <= 0;
      end else if (cnt >= lat) mem_ack <= 1'b1;
      else cnt <= cnt + 1;
   end
endmodule : ifd_far_mdl

/* File: verification/instruction_format_ea_decode_test.sv */
`timescale 1ns/1ps
`include "ifd_map.svh"
// ==========================================
// Decoder bench
module instruction_format_ea_decode_test;
   import ifd_pkg::*;
   logic mclk, nrst, fetch_valid, fetch_ready, rf_we, mem_req, mem_we, mem_long, mem_flag_read, mem_ack;
   logic carry_in, ea_valid, undefined_op, busy, got_ea, got_und;
   logic [15:0] fetch_word;
   logic [23:0] next_pc, mem_addr, ea_addr, ea;
   logic [2:0] rf_asel, rf_wsel, address_register;
   logic [3:0] rf_dsel, operation_field, data_register, branch_condition_field;
   logic [31:0] rf_adata, rf_wdata, mem_rdata, imm_data;
   logic [7:0] rf_ddata, mem_wdata;
   logic [1:0] ext_remaining;
   ifd_mode_e mode;
   ifd_size_t op_size;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   ifd_decode #(.PORT_DIR_ADDR(24'hffff10)) dut_u (.mclk, .nrst, .fetch_valid, .fetch_word, .fetch_ready,
      .next_pc, .rf_asel, .rf_adata, .rf_dsel, .rf_ddata, .rf_we, .rf_wsel, .rf_wdata, .mem_req, .mem_we,
      .mem_long, .mem_flag_read, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .carry_in, .operation_field,
      .mode, .op_size, .address_register, .data_register, .branch_condition_field, .ext_remaining, .imm_data,
      .ea_addr, .ea_valid, .undefined_op, .busy);
   ifd_far_mdl mdl_u (.mclk, .rf_asel, .rf_dsel, .rf_we, .rf_wsel, .rf_wdata, .mem_req, .mem_we, .mem_long,
      .mem_flag_read, .mem_addr, .mem_wdata, .rf_adata, .rf_ddata, .mem_rdata, .mem_ack);
   // ==========================================
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         fails++;
         report_and_stop();
      end
   end
   // ==========================================
   // Shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] wd(input logic [3:0] c, input logic [2:0] m, input logic [1:0] s,
      input logic [2:0] r, input logic [3:0] l);
      return {c, m, s, r, l};
   endfunction : wd
   // Word held until an edge with ready high takes it
   task automatic put(input logic [15:0] w);
      fetch_valid = 1'b1;
      fetch_word = w;
      while (fetch_ready !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
   endtask : put
   task automatic run(input logic [15:0] w0, input logic [15:0] e1, input logic [15:0] e2, input int n);
      put(w0);
      chk(ext_remaining, n, "ext count");
      if (n > 0) put(e1);
      if (n > 1) put(e2);
      fetch_valid = 1'b0;
      got_ea = 1'b0;
      got_und = 1'b0;
      for (int i = 0; i < 40 && !got_ea && !got_und; i++) begin
         if (ea_valid === 1'b1) ea = ea_addr;
         got_ea = got_ea | (ea_valid === 1'b1);
         got_und = (undefined_op === 1'b1);
         @(posedge mclk);
         #1;
      end
      // A decode that never completes must not slip through on a stale address
      if (!got_ea && !got_und) begin
         fails++;
         $display("wrong value at %0t ns: decode never completed", $time);
      end
   endtask : run
   // ==========================================
   // Scenarios
   task automatic t_modes();
      mdl_u.regs[2] = 32'h00123457;
      mdl_u.regs[5] = 32'hff654321;
      run(wd(`IFD_C_MOVE, IFD_M_DISP, `IFD_SZ_WORD, 3'h2, 4'h4), 16'hfff2, 16'h0, 1);
      chk(ea, (32'h00123457 + 32'hfffffff2) & 32'h00fffffe, "disp");
      chk(mode, IFD_M_DISP, "mode");
      chk(address_register, 3'h2, "areg");
      chk(data_register, 4'h4, "dreg");
      chk(op_size, `IFD_SZ_WORD, "size");
      run(wd(`IFD_C_MOVE, IFD_M_RIND, `IFD_SZ_BYTE, 3'h5, 4'h0), 16'h0, 16'h0, 0);
      chk(ea, 24'h654321, "indirect");
      run(wd(`IFD_C_MOVE, IFD_M_ABS, `IFD_SZ_BYTE, 3'h0, 4'h4), 16'h8003, 16'h0, 1);
      chk(ea, 24'hff8003, "abs16");
      run(wd(`IFD_C_MOVE, IFD_M_ABS, `IFD_SZ_BYTE, 3'h0, 4'h8), 16'hab12, 16'h3457, 2);
      chk(ea, 24'h123457, "abs24");
      run(wd(`IFD_C_ARITH, IFD_M_IMM, `IFD_SZ_LONG, 3'h0, 4'h8), 16'hab12, 16'h3457, 2);
      chk(imm_data, 32'hab123457, "imm32");
      run(wd(`IFD_C_ARITH, IFD_M_IMM, `IFD_SZ_WORD, 3'h0, 4'h4), 16'h8001, 16'h0, 1);
      chk(imm_data, 32'h00008001, "imm16");
      mdl_u.regs[3] = 32'h0000fffe;
      run(wd(`IFD_C_MOVE, IFD_M_PINC, `IFD_SZ_LONG, 3'h3, 4'h0), 16'h0, 16'h0, 0);
      chk(ea, 24'h00fffe, "postinc ea");
      chk(mdl_u.regs[3], 32'h0000fffe + 32'h4, "postinc reg");
      mdl_u.regs[4] = 32'h01000000;
      run(wd(`IFD_C_MOVE, IFD_M_PDEC, `IFD_SZ_WORD, 3'h4, 4'h0), 16'h0, 16'h0, 0);
      chk(ea, 24'hfffffe, "predec ea");
      chk(mdl_u.regs[4], 32'h00fffffe, "predec reg");
      $display("addressing test done");
   endtask : t_modes
   // Illegal encodings flagged with no bus traffic
   task automatic t_bad();
      logic [15:0] bw [5];
      int n0;
      n0 = mdl_u.n_acc;
      bw = '{wd(`IFD_C_MOVE, IFD_M_PCREL, 2'h0, 3'h0, 4'h0), wd(`IFD_C_BIT_SET, IFD_M_DISP, 2'h0, 3'h0, 4'h0),
         wd(`IFD_C_CARRY_STORE, IFD_M_ABS, `IFD_BITSRC_REG, 3'h0, 4'h0), wd(4'hf, IFD_M_REG, 2'h0, 3'h0, 4'h0),
         wd(`IFD_C_ARITH, IFD_M_PCREL, 2'h0, 3'h0, 4'h0)};
      for (int i = 0; i < 5; i++) begin
         run(bw[i], 16'h0, 16'h0, 0);
         chk(got_und, 1'b1, "undefined");
      end
      for (int m = 1; m < 6; m++) begin
         run(wd(`IFD_C_ARITH, m[2:0], 2'h0, 3'h0, 4'h0), 16'h0, 16'h0, 0);
         chk(got_und, 1'b1, "arith mode");
      end
      chk(mdl_u.n_acc, n0, "bus quiet");
      $display("illegal test done");
   endtask : t_bad
   // Byte read, one bit changed, written back, except bit test which only reads
   task automatic t_rmw();
      logic [7:0] ex [5] = '{8'h3e, 8'h3c, 8'h3e, 8'h3e, 8'h3e};
      int n0;
      carry_in = 1'b0;
      mdl_u.rd_val = 32'h3c3c3c3c;
      run(wd(`IFD_C_BIT_CLEAR, IFD_M_ABS, 2'h0, 3'h0, 4'h0), 16'h0010, 16'h0, 1);
      chk(mdl_u.wr_addr, 24'hffff10, "clear addr");
      chk(mdl_u.wr_data, 8'hfe, "write-only read");
      for (int i = 0; i < 5; i++) begin
         mdl_u.lat = i;
         // Carry high for the plain store, low for the inverted one
         carry_in = (i == 3);
         run(wd(4'h4 + i[3:0], IFD_M_ABS, 2'h0, 3'h0, 4'h1), 16'h0020, 16'h0, 1);
         chk(mdl_u.wr_addr, 24'hffff20, "rmw addr");
         chk(mdl_u.wr_data, ex[i], "rmw byte");
         chk(mdl_u.rd_flag, i == 1, "flag read");
      end
      // Bit number taken from a data register
      carry_in = 1'b0;
      mdl_u.regs[1] = 32'h00000006;
      run(wd(`IFD_C_BIT_SET, IFD_M_ABS, `IFD_BITSRC_REG, 3'h0, 4'h1), 16'h0020, 16'h0, 1);
      chk(mdl_u.wr_data, 8'h7c, "bit from reg");
      n0 = mdl_u.n_wr;
      run(wd(`IFD_C_BIT_TEST, IFD_M_ABS, 2'h0, 3'h0, 4'h1), 16'h0020, 16'h0, 1);
      chk(mdl_u.n_wr, n0, "test no write");
      mdl_u.lat = 1;
      $display("bit test done");
   endtask : t_rmw
   task automatic t_branch();
      next_pc = 24'h001000;
      run(wd(`IFD_C_BRANCH, IFD_M_PCREL, 2'h0, 3'h0, 4'hb), 16'h0081, 16'h0, 1);
      chk(ea, 24'h000f80, "d8 target");
      chk(branch_condition_field, 4'hb, "condition");
      run(wd(`IFD_C_BRANCH, IFD_M_PCREL, 2'h1, 3'h0, 4'h3), 16'h8001, 16'h0, 1);
      chk(ea, 24'hff9000, "d16 target");
      mdl_u.rd_val = 32'hab123457;
      run(wd(`IFD_C_JUMP, IFD_M_PCREL, 2'h2, 3'h0, 4'h0), 16'h0040, 16'h0, 1);
      chk(mdl_u.rd_addr, 24'h000040, "vector addr");
      chk(mdl_u.rd_long, 1'b1, "long read");
      chk(ea, 24'h123456, "indirect target");
      $display("branch test done");
   endtask : t_branch
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // ==========================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      fetch_valid = 1'b0;
      fetch_word = 16'h0;
      next_pc = 24'h0;
      carry_in = 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_modes();
      t_bad();
      t_rmw();
      t_branch();
      report_and_stop();
   end
endmodule : instruction_format_ea_decode_test
